// [design/rsw_clkmon.sv]
/*
 rsw_clkmon: clock loss detector; an edge of the rc window level closes a window.
 assumes rc_lvl is synchronised and toggles once per rc delay from an analog cell.
*/
`timescale 1ns/1ps
module rsw_clkmon (
   input  wire logic clk,
   input  wire logic rst_n,
   input  wire logic enable,
   input  wire logic e_tick,
   input  wire logic rc_lvl,
   output logic      fail
);
   logic rc_prev_r;
   logic seen_r;
   logic rc_tick;

   assign rc_tick = rc_lvl ^ rc_prev_r;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rc_prev_r <= 1'b0;
      end else begin
         rc_prev_r <= rc_lvl;
      end
   end

   // a window with no E edge means the clock is slow or gone
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         seen_r <= 1'b1;
      end else if (!enable) begin
         seen_r <= 1'b1;
      end else if (rc_tick) begin
         seen_r <= e_tick;
      end else if (e_tick) begin
         seen_r <= 1'b1;
      end
   end

   assign fail = enable && rc_tick && !seen_r && !e_tick; // R10
endmodule // rsw_clkmon

// [design/rsw_pkg.sv]
/*
 rsw_pkg: constants and types of the reset source and watchdog unit.
 assumes the unit runs on the bus E clock and is reached over AHB-Lite.
*/
package rsw_pkg;
   // register byte offsets
   localparam logic [7:0]  OFF_OPTION  = 8'h00;
   localparam logic [7:0]  OFF_CONFIG  = 8'h04;
   localparam logic [7:0]  OFF_SERVICE = 8'h08;
   localparam logic [7:0]  OFF_TEST    = 8'h0C;
   localparam logic [7:0]  OFF_STATUS  = 8'h10;
   // system_choices_register fields
   localparam int          OPT_IRQ_EDGE = 5;
   localparam int          OPT_CLK_MON  = 3;
   localparam logic [7:0]  OPT_RW_MASK = 8'hC8;
   localparam logic [7:0]  OPT_WO_MASK = 8'h33;
   localparam logic [7:0]  OPT_RESET   = 8'h10;
   // nonvolatile_setup_register fields
   localparam int          CFG_WD_OFF  = 2;
   localparam logic [7:0]  CFG_RESET   = 8'h0F;
   // factory_test_register fields
   localparam int          TST_INHIBIT = 0;
   // watchdog service values
   localparam logic [7:0]  SVC_ARM     = 8'h55;
   localparam logic [7:0]  SVC_CLR     = 8'hAA;
   // reset pin sequence, in E-clock cycles
   localparam logic [2:0]  DRIVE_CYC   = 3'h4;
   localparam logic [2:0]  WAIT_CYC    = 3'h2;
   localparam logic [2:0]  SYNC_LAT    = 3'h2;
   localparam logic [6:0]  ONCE_WINDOW = 7'h40;
   // last count before timeout: 2^15 times 1, 4, 16, 64, less one
   localparam logic [20:0] WD_LAST [4] = '{21'h007FFF, 21'h01FFFF, 21'h07FFFF, 21'h1FFFFF};
   // reset vectors
   localparam logic [15:0] VEC_EXT_NRM = 16'hFFFE;
   localparam logic [15:0] VEC_CM_NRM  = 16'hFFFC;
   localparam logic [15:0] VEC_WD_NRM  = 16'hFFFA;
   localparam logic [15:0] VEC_EXT_SPC = 16'hBFFE;
   localparam logic [15:0] VEC_CM_SPC  = 16'hBFFC;
   localparam logic [15:0] VEC_WD_SPC  = 16'hBFFA;

   typedef enum logic [1:0] {
      RS_RUN   = 2'b00,
      RS_DRIVE = 2'b01,
      RS_WAIT  = 2'b10,
      RS_EXT   = 2'b11
   } rsw_state_t;

   typedef enum logic [1:0] {
      CAUSE_EXT = 2'b00,
      CAUSE_CM  = 2'b01,
      CAUSE_WD  = 2'b10
   } rsw_cause_t;
endpackage

// [design/rsw_sync.sv]
/*
 rsw_sync: two flip-flop synchroniser, one chain per bit.
 assumes inputs come from pins outside the clock domain.
*/
`timescale 1ns/1ps
module rsw_sync #(
   parameter int           W  = 1,
   parameter logic [W-1:0] RV = '0
) (
   input  wire logic         clk,
   input  wire logic         rst_n,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   logic [W-1:0] meta_r;

   generate
      for (genvar i = 0; i < W; i++) begin : g_bit
         always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
               meta_r[i] <= RV[i];
               q[i]      <= RV[i];
            end else begin
               meta_r[i] <= d[i];
               q[i]      <= meta_r[i];
            end
         end
      end
   endgenerate
endmodule // rsw_sync

// [design/rsw_top.sv]
/*
 rsw_top: reset source sensing, watchdog, clock monitor hookup, reset vector.
 assumes clk is the bus E clock, e_tick marks live E edges, AHB-Lite master.
*/
// What this block does
// (R1) internal reset drives pin low four cycles
// (R2) sample pin two cycles later; low means external
// (R3) disable bit off enables watchdog, after reset
// (R4) special modes start with watchdog resets inhibited
// (R5) watchdog divides by 2^15 times rate scale
// (R6) rate resets shortest; written once in 64
// (R7) protected bits write once early, special anytime
// (R8) software arms with 55 then clears AA
// (R9) unserviced enabled watchdog starts system reset
// (R10) clock monitor catches missing edges, resets
// (R11) watchdog stops counting when clock stops
// (R12) below 10 kHz fails, 200 kHz passes
// (R13) monitor enable any time, reset clears it
// (R14) stop with monitor enabled produces reset
// (R15) edge select: level at 0, edge at 1
// (R16) pin reset vector FFFE or BFFE
// (R17) clock monitor vector FFFC or BFFC
// (R18) watchdog vector FFFA or BFFA
// (R19) other service values change nothing
`timescale 1ns/1ps
module rsw_top import rsw_pkg::*; (
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic             hresp,
   output logic      [31:0] hrdata,
   input  wire logic        rst_pin_i,
   output logic             rst_pin_o,
   output logic             rst_pin_oe,
   input  wire logic        mode_a_pin,
   input  wire logic        mode_b_pin,
   input  wire logic        rc_pin,
   input  wire logic        irq_n_pin,
   input  wire logic        irq_ack,
   output logic             irq_req,
   input  wire logic        e_tick,
   input  wire logic        stop_i,
   output logic             sys_rst_n,
   output logic      [15:0] reset_vector,
   output logic             special_mode,
   output logic      [7:0]  option_bits,
   output logic      [7:0]  config_bits
);
   logic [3:0]  pins_s;
   logic        pin_s, mode_b_s, irq_s, rc_s;
   rsw_state_t  st_r;
   rsw_cause_t  cause_r;
   logic [2:0]  seq_cnt_r;
   logic        srst, special_r, once_used_r, once_open;
   logic [6:0]  once_cnt_r;
   logic [7:0]  opt_r, cfg_r, wdat, dph_addr_r;
   logic        wd_off_act_r, inhibit_r, armed_r;
   logic [20:0] wd_cnt_r;
   logic        wd_en, wd_clear, wd_fire, e_run, cm_fire, cm_raw;
   logic        irq_prev_r, irq_edge_r, dph_wr_r;
   logic        wr_opt, wr_cfg, wr_svc, wr_tst;
   logic [15:0] vec_sel;

   // reset and mode pins start low so reset holds until they settle; irq idles high
   rsw_sync #(.W(4), .RV(4'h1)) u_sync (
      .clk   (clk),
      .rst_n (rst_n),
      .d     ({rst_pin_i, mode_b_pin, rc_pin, irq_n_pin}),
      .q     (pins_s)
   );
   assign pin_s    = pins_s[3];
   assign mode_b_s = pins_s[2];
   assign rc_s     = pins_s[1];
   assign irq_s    = pins_s[0];

   assign srst = st_r != RS_RUN;

   // the clock is halted in stop mode, so neither counter sees edges then
   assign e_run = e_tick && !stop_i; // R11 R14

   rsw_clkmon u_clkmon (
      .clk    (clk),
      .rst_n  (rst_n),
      .enable (opt_r[OPT_CLK_MON] && !srst),
      .e_tick (e_run),
      .rc_lvl (rc_s),
      .fail   (cm_raw)
   );
   // no edge in one rc delay: under 10 kHz always, 200 kHz never
   assign cm_fire = cm_raw; // R10 R12

   // reset pin sequencer; the wait covers the synchroniser latency
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_r      <= RS_EXT;
         seq_cnt_r <= 3'h0;
      end else begin
         unique case (st_r)
            RS_RUN: begin
               seq_cnt_r <= 3'h0;
               if (!pin_s) begin
                  st_r <= RS_EXT;
               end else if (cm_fire || wd_fire) begin
                  st_r <= RS_DRIVE; // R9 R10
               end
            end
            RS_DRIVE: begin
               if (seq_cnt_r == DRIVE_CYC - 3'h1) begin // R1
                  st_r      <= RS_WAIT;
                  seq_cnt_r <= 3'h0;
               end else begin
                  seq_cnt_r <= seq_cnt_r + 3'h1;
               end
            end
            RS_WAIT: begin
               if (seq_cnt_r == WAIT_CYC + SYNC_LAT - 3'h1) begin
                  st_r <= pin_s ? RS_RUN : RS_EXT; // R2
               end else begin
                  seq_cnt_r <= seq_cnt_r + 3'h1;
               end
            end
            RS_EXT: begin
               if (pin_s) begin
                  st_r <= RS_RUN;
               end
            end
         endcase
      end
   end

   assign rst_pin_o  = 1'b0;
   assign rst_pin_oe = st_r == RS_DRIVE; // R1
   assign sys_rst_n  = !srst;

   // clock loss outranks the watchdog when both fire together
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cause_r <= CAUSE_EXT;
      end else if (st_r == RS_RUN && !pin_s) begin
         cause_r <= CAUSE_EXT;
      end else if (st_r == RS_RUN && cm_fire) begin
         cause_r <= CAUSE_CM;
      end else if (st_r == RS_RUN && wd_fire) begin
         cause_r <= CAUSE_WD;
      end else if (st_r == RS_WAIT && seq_cnt_r == WAIT_CYC + SYNC_LAT - 3'h1 && !pin_s) begin
         cause_r <= CAUSE_EXT; // R2
      end
   end

   always_comb begin
      unique case (cause_r)
         CAUSE_CM: vec_sel = mode_b_s ? VEC_CM_NRM : VEC_CM_SPC; // R17
         CAUSE_WD: vec_sel = mode_b_s ? VEC_WD_NRM : VEC_WD_SPC; // R18
         default:  vec_sel = mode_b_s ? VEC_EXT_NRM : VEC_EXT_SPC; // R16
      endcase
   end

   // mode straps follow the pin while reset is held and freeze at release
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         special_r    <= 1'b0;
         reset_vector <= VEC_EXT_NRM;
      end else if (srst) begin
         special_r    <= !mode_b_s;
         reset_vector <= vec_sel;
      end
   end
   assign special_mode = special_r;

   // bus cycles since release, for the write-once window
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         once_cnt_r  <= 7'h0;
         once_used_r <= 1'b0;
      end else if (srst) begin
         once_cnt_r  <= 7'h0;
         once_used_r <= 1'b0;
      end else begin
         if (once_cnt_r != ONCE_WINDOW) begin
            once_cnt_r <= once_cnt_r + 7'h1;
         end
         if (wr_opt && !special_r) begin
            once_used_r <= 1'b1;
         end
      end
   end
   assign once_open = special_r || (once_cnt_r < ONCE_WINDOW && !once_used_r); // R6 R7

   // AHB-Lite slave: zero wait states, always OKAY, unmapped reads zero
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         dph_wr_r   <= 1'b0;
         dph_addr_r <= 8'h00;
      end else if (hready) begin
         dph_wr_r   <= hsel && htrans[1] && hwrite && hsize == 3'h2;
         dph_addr_r <= haddr[7:0];
      end
   end
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;
   assign wdat      = hwdata[7:0];
   assign wr_opt    = dph_wr_r && dph_addr_r == OFF_OPTION;
   assign wr_cfg    = dph_wr_r && dph_addr_r == OFF_CONFIG;
   assign wr_svc    = dph_wr_r && dph_addr_r == OFF_SERVICE;
   assign wr_tst    = dph_wr_r && dph_addr_r == OFF_TEST;

   always_comb begin
      unique case (dph_addr_r)
         OFF_OPTION:  hrdata = {24'h000000, opt_r};
         OFF_CONFIG:  hrdata = {24'h000000, cfg_r};
         OFF_TEST:    hrdata = {31'h00000000, inhibit_r};
         OFF_STATUS:  hrdata = {reset_vector, 9'h000, armed_r, wd_en, special_r, st_r, cause_r};
         default:     hrdata = 32'h00000000;
      endcase
   end

   // bit 2 is unimplemented and stays zero
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         opt_r <= OPT_RESET;
      end else if (srst) begin
         opt_r <= OPT_RESET; // R6 R13
      end else if (wr_opt) begin
         opt_r <= (opt_r & ~(OPT_RW_MASK | (once_open ? OPT_WO_MASK : 8'h00)))
                | (wdat & (OPT_RW_MASK | (once_open ? OPT_WO_MASK : 8'h00))); // R7 R13
      end
   end
   assign option_bits = opt_r;

   // setup bits are nonvolatile: only power-on restores them
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cfg_r <= CFG_RESET;
      end else if (wr_cfg) begin
         cfg_r <= wdat;
      end
   end
   assign config_bits = cfg_r;

   // a new disable value only counts from the next system reset
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wd_off_act_r <= CFG_RESET[CFG_WD_OFF];
         inhibit_r    <= 1'b0;
      end else if (srst) begin
         wd_off_act_r <= cfg_r[CFG_WD_OFF]; // R3
         inhibit_r    <= !mode_b_s; // R4
      end else if (wr_tst && special_r) begin
         inhibit_r    <= wdat[TST_INHIBIT]; // R4
      end
   end

   assign wd_en    = !wd_off_act_r && !inhibit_r; // R3
   assign wd_clear = wr_svc && wdat == SVC_CLR && armed_r; // R8

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         armed_r <= 1'b0;
      end else if (srst) begin
         armed_r <= 1'b0;
      end else if (wr_svc && wdat == SVC_ARM) begin
         armed_r <= 1'b1; // R8
      end else if (wd_clear) begin
         armed_r <= 1'b0; // R19
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wd_cnt_r <= 21'h000000;
      end else if (srst || wd_clear) begin
         wd_cnt_r <= 21'h000000;
      end else if (wd_en && e_run) begin
         wd_cnt_r <= wd_cnt_r + 21'h000001; // R5 R11
      end
   end
   assign wd_fire = wd_en && e_run && wd_cnt_r == WD_LAST[opt_r[1:0]]; // R5 R9

   // edge latch: a new edge in the ack cycle is kept
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         irq_prev_r <= 1'b1;
         irq_edge_r <= 1'b0;
      end else begin
         irq_prev_r <= irq_s;
         if (srst) begin
            irq_edge_r <= 1'b0;
         end else if (irq_prev_r && !irq_s) begin
            irq_edge_r <= 1'b1;
         end else if (irq_ack) begin
            irq_edge_r <= 1'b0;
         end
      end
   end
   assign irq_req = !srst && (opt_r[OPT_IRQ_EDGE] ? irq_edge_r : !irq_s); // R15

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   property p_drive_len;
      $rose(rst_pin_oe) |-> rst_pin_oe[*4] ##1 !rst_pin_oe;
   endproperty
   a_drive_len: assert property (p_drive_len) else $error("pin drive not four cycles"); // R1
   property p_classify;
      $fell(rst_pin_oe) ##3 !pin_s |=> st_r == RS_EXT && cause_r == CAUSE_EXT;
   endproperty
   a_classify: assert property (p_classify) else $error("low pin not taken as external"); // R2
   property p_wd_hold;
      !wd_en && !srst && !wd_clear |=> $stable(wd_cnt_r);
   endproperty
   a_wd_hold: assert property (p_wd_hold) else $error("disabled watchdog counted"); // R3
   property p_inhibit_start;
      $rose(sys_rst_n) && special_r |-> inhibit_r && !wd_en;
   endproperty
   a_inhibit_start: assert property (p_inhibit_start) else $error("special mode not inhibited"); // R4
   property p_wd_step;
      wd_en && e_run && !srst && !wd_clear && wd_cnt_r != WD_LAST[opt_r[1:0]]
         |=> wd_cnt_r == $past(wd_cnt_r) + 21'h000001;
   endproperty
   a_wd_step: assert property (p_wd_step) else $error("watchdog did not step"); // R5
   property p_once;
      wr_opt && !srst && !special_r && once_cnt_r == ONCE_WINDOW |=> $stable(opt_r[1:0]);
   endproperty
   a_once: assert property (p_once) else $error("rate written after window"); // R7
   property p_wd_fire;
      st_r == RS_RUN && pin_s && wd_fire && !cm_fire |=> rst_pin_oe && cause_r == CAUSE_WD;
   endproperty
   a_wd_fire: assert property (p_wd_fire) else $error("timeout without reset"); // R9
   property p_cm_fire;
      st_r == RS_RUN && pin_s && cm_fire |=> rst_pin_oe ##4 cause_r == CAUSE_CM || !pin_s;
   endproperty
   a_cm_fire: assert property (p_cm_fire) else $error("clock loss without reset"); // R10
   property p_cme_clear;
      srst |=> !opt_r[OPT_CLK_MON];
   endproperty
   a_cme_clear: assert property (p_cme_clear) else $error("reset left monitor on"); // R13
   property p_vec_wd;
      $rose(sys_rst_n) && cause_r == CAUSE_WD
         |-> reset_vector == (special_r ? VEC_WD_SPC : VEC_WD_NRM);
   endproperty
   a_vec_wd: assert property (p_vec_wd) else $error("wrong watchdog vector"); // R18
   property p_vec_ext;
      $rose(sys_rst_n) && cause_r == CAUSE_EXT
         |-> reset_vector == (special_r ? VEC_EXT_SPC : VEC_EXT_NRM);
   endproperty
   a_vec_ext: assert property (p_vec_ext) else $error("wrong external vector"); // R16
   property p_svc_other;
      wr_svc && !srst && wdat != SVC_ARM && wdat != SVC_CLR |=> $stable(armed_r);
   endproperty
   a_svc_other: assert property (p_svc_other) else $error("stray value moved arming"); // R19

   c_wd_reset: cover property (wd_fire && st_r == RS_RUN);
   c_cm_reset: cover property (cm_fire && st_r == RS_RUN);
   c_ext_seen: cover property ($fell(rst_pin_oe) ##3 !pin_s);
   c_service:  cover property (wd_clear && wd_cnt_r != 21'h000000);
endmodule // rsw_top

// [verif/rsw_rst_ckt.sv]
/*
 rsw_rst_ckt: external reset circuit on the open-drain reset pin.
 assumes a pull-up on the pin; pull asks for an external reset,
 stretch keeps the pin low that many cycles past a device release.
*/
`timescale 1ns/1ps
module rsw_rst_ckt (
   input  wire logic       clk,
   input  wire logic       pull,
   input  wire logic [7:0] stretch,
   input  wire logic       rst_pin_o,
   input  wire logic       rst_pin_oe,
   output logic            pin_lvl
);
   logic [7:0] hold_r = 8'h00;

   // a slow circuit holds the pin after the device lets go
   always @(posedge clk) begin
      if (rst_pin_oe) begin
         hold_r <= stretch;
      end else if (hold_r != 8'h00) begin
         hold_r <= hold_r - 8'h01;
      end
   end

   // open drain with pull-up: a released pin reads high, not its last value
   assign pin_lvl = !((rst_pin_oe && !rst_pin_o) || pull || (hold_r != 8'h00));
endmodule // rsw_rst_ckt

// [verif/rsw_top_tb.sv]
/*
 rsw_top_tb: self-checking bench of the reset source and watchdog unit.
 assumes the AHB-Lite slave answers when hreadyout is seen high and
 the reset pin is joined to the external reset circuit model.
*/
`timescale 1ns/1ps
module rsw_top_tb import rsw_pkg::*;;
   logic        clk, rst_n, hsel, hwrite, hreadyout, hresp;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic        pin_lvl, rst_pin_o, rst_pin_oe, pull, mode_b, rc;
   logic        irq_n, irq_ack, irq_req, e_tick, stop_i, sys_rst_n, special_mode;
   logic [15:0] reset_vector;
   logic [7:0]  option_bits, config_bits, stretch;
   int          mismatches, check_count, oe_cnt, n;

   rsw_top DUT (
      .clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .rst_pin_i(pin_lvl),
      .rst_pin_o(rst_pin_o), .rst_pin_oe(rst_pin_oe), .mode_a_pin(1'b1),
      .mode_b_pin(mode_b), .rc_pin(rc), .irq_n_pin(irq_n), .irq_ack(irq_ack),
      .irq_req(irq_req), .e_tick(e_tick), .stop_i(stop_i), .sys_rst_n(sys_rst_n),
      .reset_vector(reset_vector), .special_mode(special_mode),
      .option_bits(option_bits), .config_bits(config_bits)
   );

   rsw_rst_ckt ckt (
      .clk(clk), .pull(pull), .stretch(stretch), .rst_pin_o(rst_pin_o),
      .rst_pin_oe(rst_pin_oe), .pin_lvl(pin_lvl)
   );

   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   always @(posedge clk) begin
      if (rst_pin_oe === 1'b1) oe_cnt++;
   end

   task automatic complete_run();
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      check_count++;
      if (g !== e) begin
         mismatches++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic tmo(input string nm, input logic ok);
      chk(nm, 32'h1, {31'h0, ok});
      if (ok !== 1'b1) complete_run();
   endtask

   task automatic cyc(input int k);
      repeat (k) @(posedge clk);
   endtask

   // taken at the edge that ends the phase, before that edge's updates land
   task automatic phase();
      logic ok;
      n = 0;
      do begin
         @(posedge clk);
         ok = hreadyout;
         rd = hrdata;
         n++;
      end while (ok !== 1'b1 && n < 20);
      tmo("hreadyout", ok);
   endtask

   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      haddr <= {24'h000000, a};
      hwrite <= w;
      htrans <= 2'h2;
      phase();
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      phase();
   endtask

   task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h00000000);
      chk(nm, e, rd);
   endtask

   task automatic wait_sys(input logic v, input int lim);
      n = 0;
      do begin
         @(negedge clk);
         n++;
      end while (sys_rst_n !== v && n < lim);
      tmo("sys_rst_n", sys_rst_n === v);
      @(posedge clk);
   endtask

   task automatic rc_tog(input int k);
      repeat (k) begin
         rc <= ~rc;
         cyc(10);
      end
   endtask

   // closes one ticking window and one dead one, so the monitor fires
   task automatic cm_fire();
      oe_cnt = 0;
      rc_tog(1);
      rc <= ~rc;
      wait_sys(1'b0, 20);
      e_tick <= 1'b1;
      stop_i <= 1'b0;
   endtask

   task automatic see_rst(input logic [31:0] st);
      wait_sys(1'b1, 200);
      chk("drive cycles", 32'd4, oe_cnt);
      chk("vector", {16'h0000, st[31:16]}, {16'h0000, reset_vector});
      rchk("status", OFF_STATUS, st);
   endtask

   initial begin
      rst_n = 1'b0;
      hsel = 1'b0;
      haddr = 32'h00000000;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h00000000;
      mode_b = 1'b1;
      rc = 1'b0;
      irq_n = 1'b1;
      irq_ack = 1'b0;
      e_tick = 1'b1;
      stop_i = 1'b0;
      pull = 1'b0;
      stretch = 8'h00;
      mismatches = 0;
      check_count = 0;
      cyc(3);
      rst_n <= 1'b1;
      wait_sys(1'b1, 100);
      rchk("status", OFF_STATUS, 32'hFFFE0000);
      rchk("option", OFF_OPTION, 32'h00000010);
      bus(1'b1, OFF_OPTION, 32'h00000005);
      rchk("option", OFF_OPTION, 32'h00000001);
      bus(1'b1, OFF_OPTION, 32'h000000FF);
      rchk("option", OFF_OPTION, 32'h000000C9);
      bus(1'b1, 8'h14, 32'h000000FF);
      rchk("unmapped", 8'h14, 32'h00000000);
      irq_n <= 1'b0;
      cyc(4);
      chk("irq_req", 32'h1, {31'h0, irq_req});
      irq_n <= 1'b1;
      cyc(4);
      chk("irq_req", 32'h0, {31'h0, irq_req});
      $display("test options done");
      bus(1'b1, OFF_CONFIG, 32'h0000000B);
      rchk("config", OFF_CONFIG, 32'h0000000B);
      chk("config_bits", 32'h0000000B, {24'h000000, config_bits});
      pull <= 1'b1;
      wait_sys(1'b0, 10);
      cyc(8);
      pull <= 1'b0;
      wait_sys(1'b1, 20);
      rchk("status", OFF_STATUS, 32'hFFFE0020);
      cyc(70);
      bus(1'b1, OFF_OPTION, 32'h00000003);
      rchk("option", OFF_OPTION, 32'h00000010);
      $display("test external reset done");
      cyc(20000);
      bus(1'b1, OFF_SERVICE, 32'h00000055);
      rchk("status", OFF_STATUS, 32'hFFFE0060);
      bus(1'b1, OFF_SERVICE, 32'h00000012);
      rchk("status", OFF_STATUS, 32'hFFFE0060);
      bus(1'b1, OFF_SERVICE, 32'h000000AA);
      rchk("status", OFF_STATUS, 32'hFFFE0020);
      oe_cnt = 0;
      wait_sys(1'b0, 33000);
      chk("timeout", 32'h1, {31'h0, (n > 32750 && n < 32790)});
      see_rst(32'hFFFA0022);
      $display("test watchdog done");
      bus(1'b1, OFF_OPTION, 32'h00000008);
      rc_tog(3);
      chk("sys_rst_n", 32'h1, {31'h0, sys_rst_n});
      stop_i <= 1'b1;
      cm_fire();
      see_rst(32'hFFFC0021);
      rchk("option", OFF_OPTION, 32'h00000010);
      $display("test clock monitor done");
      bus(1'b1, OFF_OPTION, 32'h00000008);
      stretch <= 8'd12;
      e_tick <= 1'b0;
      cm_fire();
      see_rst(32'hFFFE0020);
      stretch <= 8'h00;
      $display("test stretched pin done");
      mode_b <= 1'b0;
      rst_n <= 1'b0;
      cyc(3);
      rst_n <= 1'b1;
      wait_sys(1'b1, 100);
      rchk("status", OFF_STATUS, 32'hBFFE0010);
      chk("special", 32'h1, {31'h0, special_mode});
      rchk("test reg", OFF_TEST, 32'h00000001);
      bus(1'b1, OFF_TEST, 32'h00000000);
      rchk("test reg", OFF_TEST, 32'h00000000);
      bus(1'b1, OFF_OPTION, 32'h00000028);
      rchk("option", OFF_OPTION, 32'h00000028);
      chk("option_bits", 32'h00000028, {24'h000000, option_bits});
      irq_n <= 1'b0;
      cyc(4);
      irq_n <= 1'b1;
      cyc(4);
      chk("irq_req", 32'h1, {31'h0, irq_req});
      irq_ack <= 1'b1;
      cyc(1);
      irq_ack <= 1'b0;
      cyc(3);
      chk("irq_req", 32'h0, {31'h0, irq_req});
      e_tick <= 1'b0;
      cm_fire();
      see_rst(32'hBFFC0011);
      $display("test special mode done");
      complete_run();
   end
endmodule // rsw_top_tb
